// >>> shared/qdac_params.svh
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH
`define QDAC_WORD_BITS 24
`define QDAC_ADDR_HI 23
`define QDAC_ADDR_LO 22
`define QDAC_LD_HI 21
`define QDAC_LD_LO 20
`define QDAC_SEL_HI 18
`define QDAC_SEL_LO 17
`define QDAC_PD_FLAG 16
`define QDAC_PD_HI 15
`define QDAC_PD_LO 14
`define QDAC_DATA_MSB 15
`define QDAC_DATA_LSB 4
`define QDAC_CODE_RST 12'h000
`define QDAC_PD_RST 2'h0
`endif

// >>> shared/qdac_pkg.sv
package qdac_pkg;
  typedef enum logic [1:0] {
    QDAC_STORE = 2'h0,
    QDAC_LOAD_ONE = 2'h1,
    QDAC_LOAD_ALL = 2'h2,
    QDAC_BROADCAST = 2'h3
  } qdac_ld_t;
  typedef enum logic [1:0] {
    QDAC_IDLE = 2'h0,
    QDAC_SHIFT = 2'h1,
    QDAC_LOCKED = 2'h3
  } qdac_state_t;
endpackage

// >>> hw/qdac_decoder.sv
//Behaviour
//- act only when address bits match straps, or on broadcast
//- store-only command writes selected buffer
//- power-down command stored into selected buffer
//- load-one writes buffer and converter register
//- load-one power-down applies to converter at once
//- load-all writes buffer then loads all
//- broadcast low select reloads all from buffers
//- broadcast high select loads word everywhere
//- converter update on the 24th falling edge
//- early frame rise discards whole frame
//- converter registers zero after power-up
//- reference on after power-up until changed; here ref_powered stays 1 and no command changes it
//- strobe rising edge copies buffers to converters
//- untouched buffer leaves output unchanged
//- enable high ignores serial port
//- msb first, bits 15..4 are code
//- lock after 24 bits until frame falls
//- power-down mode codes kept, contents kept
`timescale 1ns/100ps
`default_nettype none
`include "qdac_params.svh"
module qdac_decoder
  import qdac_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int CODE_BITS = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // serial pins
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic async_load_strobe,
  input wire logic enable,
  // address straps
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  // converter state
  output logic [CHANNELS*CODE_BITS-1:0] conv_code,
  output logic [CHANNELS*2-1:0] conv_pd_mode,
  output logic ref_powered
);
  // ***************
  // pin synchronisers
  // ***************
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] last_b;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_a <= 5'h1f;
      sync_b <= 5'h1f;
      last_b <= 5'h1f;
    end else begin
      sync_a <= {enable, addr_strap_hi, async_load_strobe, serial_clk,
        frame_sel_n};
      sync_b <= sync_a;
      last_b <= sync_b;
    end
  end
  wire fs_n = sync_b[0];
  wire fs_fall = last_b[0] & ~fs_n;
  wire fs_rise = ~last_b[0] & fs_n;
  wire sclk_fall = last_b[1] & ~sync_b[1];
  // reset value 1 hides a false edge just after reset
  wire strobe_rise = ~last_b[2] & sync_b[2];
  wire strap_hi = sync_b[3];
  wire en_s = sync_b[4];
  logic data_a;
  logic data_b;
  logic strap_lo_a;
  logic strap_lo_b;
  always_ff @(posedge clock) begin
    if (reset) begin
      data_a <= 1'b0;
      data_b <= 1'b0;
      strap_lo_a <= 1'b0;
      strap_lo_b <= 1'b0;
    end else begin
      data_a <= serial_data;
      data_b <= data_a;
      strap_lo_a <= addr_strap_lo;
      strap_lo_b <= strap_lo_a;
    end
  end
  // ***************
  // frame shifter
  // ***************
  qdac_state_t state;
  qdac_state_t next_state;
  logic [`QDAC_WORD_BITS-1:0] input_shift_word;
  logic [4:0] bit_count;
  wire last_bit = (bit_count == 5'(`QDAC_WORD_BITS - 1));
  wire port_on = ~en_s;
  wire take_bit = port_on && state == QDAC_SHIFT && sclk_fall && !fs_n;
  wire word_done = take_bit && last_bit;
  always_comb begin
    next_state = state;
    case (state)
      QDAC_IDLE: begin
        if (port_on && fs_fall) begin
          next_state = QDAC_SHIFT;
        end
      end
      QDAC_SHIFT: begin
        if (fs_n || !port_on) begin
          next_state = QDAC_IDLE;
        end else if (word_done) begin
          next_state = QDAC_LOCKED;
        end
      end
      QDAC_LOCKED: begin
        // disabling drops the lock, a new frame still needs a fall
        if (!port_on) begin
          next_state = QDAC_IDLE;
        end else if (fs_fall) begin
          next_state = QDAC_SHIFT;
        end
      end
      default: next_state = QDAC_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= QDAC_IDLE;
      bit_count <= 5'h00;
      input_shift_word <= 24'h000000;
    end else begin
      state <= next_state;
      if (next_state == QDAC_IDLE || (fs_fall && port_on)) begin
        bit_count <= 5'h00;
        input_shift_word <= 24'h000000;
      end else if (take_bit) begin
        input_shift_word <= {input_shift_word[`QDAC_WORD_BITS-2:0], data_b};
        bit_count <= bit_count + 5'h01;
      end
    end
  end
  // ***************
  // command decode
  // ***************
  wire [`QDAC_WORD_BITS-1:0] word = {input_shift_word[`QDAC_WORD_BITS-2:0],
    data_b};
  wire [1:0] ld_bits = word[`QDAC_LD_HI:`QDAC_LD_LO];
  wire load_cmd_hi = ld_bits[1];
  wire load_cmd_lo = ld_bits[0];
  wire [1:0] sel = word[`QDAC_SEL_HI:`QDAC_SEL_LO];
  wire powerdown_flag = word[`QDAC_PD_FLAG];
  wire pd_mode_hi = word[`QDAC_PD_HI];
  wire pd_mode_lo = word[`QDAC_PD_LO];
  wire [1:0] pd_word = powerdown_flag ? {pd_mode_hi, pd_mode_lo} : 2'h0;
  wire [CODE_BITS-1:0] code_word = word[`QDAC_DATA_MSB:`QDAC_DATA_LSB];
  wire is_bcast = load_cmd_hi & load_cmd_lo;
  wire addr_ok = word[`QDAC_ADDR_HI] == strap_hi &&
    word[`QDAC_ADDR_LO] == strap_lo_b;
  wire act = word_done && (addr_ok || is_bcast);
  wire bcast_write = is_bcast && word[`QDAC_SEL_HI];
  wire load_all = act && (ld_bits == QDAC_LOAD_ALL || is_bcast);
  wire load_one = act && ld_bits == QDAC_LOAD_ONE;
  // ***************
  // channel storage
  // ***************
  logic [CHANNELS*CODE_BITS-1:0] buf_code;
  logic [CHANNELS*2-1:0] buf_pd;
  // reference stays on, no change command decoded here
  always_ff @(posedge clock) begin
    if (reset) begin
      ref_powered <= 1'b1;
    end else begin
      ref_powered <= 1'b1;
    end
  end
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      wire hit = act && ((!is_bcast && sel == 2'(ch)) || bcast_write);
      wire [CODE_BITS-1:0] new_code = (hit && !powerdown_flag) ? code_word :
        buf_code[ch*CODE_BITS +: CODE_BITS];
      wire [1:0] new_pd = hit ? pd_word : buf_pd[ch*2 +: 2];
      wire conv_load = load_all || (load_one && hit) || strobe_rise;
      always_ff @(posedge clock) begin
        if (reset) begin
          buf_code[ch*CODE_BITS +: CODE_BITS] <= `QDAC_CODE_RST;
          buf_pd[ch*2 +: 2] <= `QDAC_PD_RST;
          conv_code[ch*CODE_BITS +: CODE_BITS] <= `QDAC_CODE_RST;
          conv_pd_mode[ch*2 +: 2] <= `QDAC_PD_RST;
        end else begin
          buf_code[ch*CODE_BITS +: CODE_BITS] <= new_code;
          buf_pd[ch*2 +: 2] <= new_pd;
          if (conv_load) begin
            conv_code[ch*CODE_BITS +: CODE_BITS] <= new_code;
            conv_pd_mode[ch*2 +: 2] <= new_pd;
          end
        end
      end
      conv_copy_a: assert property (@(posedge clock) disable iff (reset)
        conv_load |=> conv_code[ch*CODE_BITS +: CODE_BITS] ==
        buf_code[ch*CODE_BITS +: CODE_BITS])
        else $error("converter not loaded from buffer");
      store_only_a: assert property (@(posedge clock) disable iff (reset)
        (act && ld_bits == QDAC_STORE && !strobe_rise) |=>
        $stable(conv_code[ch*CODE_BITS +: CODE_BITS]))
        else $error("store-only changed converter");
    end
  endgenerate
  // ***************
  // checks
  // ***************
  sequence frame_start_s;
    state == QDAC_IDLE && port_on && fs_fall;
  endsequence
  sequence aborted_s;
    state == QDAC_SHIFT && fs_n;
  endsequence
  frame_enter_a: assert property (@(posedge clock) disable iff (reset)
    frame_start_s |=> state == QDAC_SHIFT)
    else $error("frame not started");
  abort_clear_a: assert property (@(posedge clock) disable iff (reset)
    aborted_s |=> state == QDAC_IDLE && bit_count == 5'h00)
    else $error("abort did not clear shifter");
  abort_keep_a: assert property (@(posedge clock) disable iff (reset)
    (aborted_s and !strobe_rise) |=> $stable(conv_code))
    else $error("abort changed converter");
  lock_hold_a: assert property (@(posedge clock) disable iff (reset)
    (state == QDAC_LOCKED && port_on && !fs_fall) |=>
    state == QDAC_LOCKED)
    else $error("shifter left lock");
  enable_off_a: assert property (@(posedge clock) disable iff (reset)
    en_s |=> state == QDAC_IDLE)
    else $error("serial port active while disabled");
  count_done_a: assert property (@(posedge clock) disable iff (reset)
    word_done |-> bit_count == 5'h17)
    else $error("update not on 24th edge");
  mismatch_a: assert property (@(posedge clock) disable iff (reset)
    (word_done && !addr_ok && !is_bcast && !strobe_rise) |=>
    $stable(conv_code) && $stable(buf_code))
    else $error("unaddressed word acted on");
  ref_on_a: assert property (@(posedge clock) disable iff (reset)
    ref_powered)
    else $error("reference off");
endmodule
`default_nettype wire

// >>> bench/qdac_host.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// host
// ********
module qdac_host (
  // clock
  input wire logic clock,
  // serial pins
  output logic frame_sel_n,
  output logic serial_clk,
  output logic serial_data
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
    serial_data = 1'b0;
  end
  task automatic send(input logic [23:0] word, input int nbits);
    @(posedge clock) frame_sel_n <= 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      @(posedge clock) serial_data <= i < 0 ? 1'b1 : word[i];
      repeat (3) @(posedge clock);
      @(posedge clock) serial_clk <= 1'b0;
      repeat (3) @(posedge clock);
      @(posedge clock) serial_clk <= 1'b1;
    end
    repeat (4) @(posedge clock);
    @(posedge clock) frame_sel_n <= 1'b1;
    // released line flips so a stale bit never looks valid
    serial_data <= ~serial_data;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// bench
// ********
module tb;
  logic clock, reset, strobe, enable, fs_n, sclk, sdata, ref_o;
  logic [47:0] code_o;
  logic [1:0] strap;
  logic [7:0] pd_o;
  logic [3:0][11:0] bc, ec;
  logic [3:0][1:0] bp, ep;
  int n_errors, num_checks;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  qdac_host i_qdac_host (.clock(clock), .frame_sel_n(fs_n),
    .serial_clk(sclk), .serial_data(sdata));
  qdac_decoder i_qdac_decoder (.clock(clock), .reset(reset),
    .frame_sel_n(fs_n), .serial_clk(sclk), .serial_data(sdata),
    .async_load_strobe(strobe), .enable(enable),
    .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]),
    .conv_code(code_o), .conv_pd_mode(pd_o), .ref_powered(ref_o));
  task automatic chk(input logic [47:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk_all();
    chk(code_o, ec);
    chk({40'h0, pd_o}, {40'h0, ep});
  endtask
  function automatic logic [23:0] word(logic [1:0] a, ld, sel,
    logic pd, logic [11:0] d);
    return {a, ld, 1'b0, sel, pd, d, 4'h0};
  endfunction
  task automatic put(input int c, input logic [23:0] w);
    if (w[16]) bp[c] = w[15:14];
    else begin
      bc[c] = w[15:4];
      bp[c] = 2'h0;
    end
  endtask
  // model of the command decode against the current straps
  task automatic wr(input logic [23:0] w, input int n);
    i_qdac_host.send(w, n);
    repeat (8) @(posedge clock);
    if (n >= 24 && !enable && (w[21:20] == 2'h3 || w[23:22] == strap))
    begin
      if (w[21:20] != 2'h3) put(w[18:17], w);
      else if (w[18]) for (int c = 0; c < 4; c++) put(c, w);
      if (w[21:20] == 2'h1) begin
        ec[w[18:17]] = bc[w[18:17]];
        ep[w[18:17]] = bp[w[18:17]];
      end
      if (w[21]) begin
        ec = bc;
        ep = bp;
      end
    end
    chk_all();
  endtask
  task automatic load_strobe();
    @(posedge clock) strobe <= 1'b1;
    repeat (8) @(posedge clock);
    strobe <= 1'b0;
    repeat (8) @(posedge clock);
    ec = bc;
    ep = bp;
    chk_all();
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    strobe = 1'b0;
    enable = 1'b0;
    strap = 2'h2;
    n_errors = 0;
    num_checks = 0;
    {bc, ec, bp, ep} = '0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    chk_all();
    chk({47'h0, ref_o}, 48'h1);
    for (int c = 0; c < 4; c++)
      wr(word(2'h2, 2'h0, c[1:0], 1'b0, 12'ha50 + c[11:0]), 24);
    wr(word(2'h2, 2'h1, 2'h1, 1'b0, 12'h123), 24);
    wr(word(2'h1, 2'h1, 2'h2, 1'b0, 12'hfff), 24);
    wr(word(2'h2, 2'h0, 2'h2, 1'b1, 12'h400), 24);
    for (int m = 1; m < 4; m++)
      wr(word(2'h2, 2'h1, 2'h3, 1'b1, {m[1:0], 10'h0}), 24);
    wr(word(2'h2, 2'h2, 2'h0, 1'b0, 12'h777), 24);
    wr(word(2'h2, 2'h0, 2'h1, 1'b0, 12'h3c0), 24);
    wr(word(2'h0, 2'h3, 2'h0, 1'b0, 12'hbad), 24);
    wr(word(2'h2, 2'h1, 2'h0, 1'b0, 12'h0f0), 20);
    wr(word(2'h2, 2'h1, 2'h0, 1'b0, 12'h0e0), 26);
    enable <= 1'b1;
    wr(word(2'h2, 2'h1, 2'h0, 1'b0, 12'h0d0), 24);
    enable <= 1'b0;
    repeat (4) @(posedge clock);
    wr(word(2'h2, 2'h0, 2'h0, 1'b0, 12'h111), 24);
    load_strobe();
    wr(word(2'h1, 2'h3, 2'h2, 1'b0, 12'h9ab), 24);
    wr(word(2'h0, 2'h3, 2'h2, 1'b1, 12'hc00), 24);
    strap <= 2'h1;
    repeat (4) @(posedge clock);
    wr(word(2'h1, 2'h1, 2'h2, 1'b0, 12'h5a5), 24);
    wr(word(2'h2, 2'h1, 2'h3, 1'b0, 12'h6b6), 24);
    report_and_stop();
  end
endmodule
`default_nettype wire
